/* File: hscp_pkg.sv */
// Package of register addresses, widths and timing counts for the host serial command port.
`default_nettype none
package hscp_pkg;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1f;
   localparam logic [7:0] ADDR_STATUS      = 8'h40;
   localparam logic [7:0] ADDR_STREAM_IN   = 8'h49;
   localparam logic [7:0] ADDR_STREAM_OUT  = 8'h48;
   localparam logic [7:0] ADDR_FIFO_FLUSH  = 8'h01;
   localparam logic [7:0] ADDR_GEN_RESET   = 8'h02;
   localparam int         ADDR_W           = 8;
   localparam int         REG_W            = 16;
   localparam int         BYTE_W           = 8;
   localparam int         FIFO_DEPTH       = 128;
   localparam int         CNT_W            = 5;
   localparam logic [15:0] MASK_RESET      = 16'h0000;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam int         ST_FIFO_LEVEL    = 0;
   localparam int         ST_FIFO_OVERRUN  = 1;
   localparam int         ST_FIFO_UNDERRUN = 2;
   localparam int         ST_FIFO_EMPTY    = 3;
   localparam int         ST_EVENT_W       = 4;
   localparam int         CLK_PERIOD_NS    = 8;
endpackage
`default_nettype wire

/* File: hscp_fifo.sv */
// Byte FIFO that carries streamed words across transactions.
`timescale 1ns/1ns
`default_nettype none
module hscp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   input  wire logic             flush_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             rd_ready_i,
   output logic                  rd_valid_o,
   output logic      [WIDTH-1:0] rd_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("hscp_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic             do_wr;
   logic             do_rd;
   assign level_o    = wp_r - rp_r;
   assign wr_ready_o = (level_o != DEPTH[AW:0]);
   assign rd_valid_o = (level_o != '0);
   assign rd_data_o  = mem_r[rp_r[AW-1:0]];
   assign do_wr      = wr_valid_i && wr_ready_o;
   assign do_rd      = rd_ready_i && rd_valid_o;
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && do_wr) begin
         mem_r[wp_r[AW-1:0]] <= wr_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (ce_i) begin
         if (flush_i) begin
            wp_r <= '0;
            rp_r <= '0;
         end else begin
            if (do_wr) wp_r <= wp_r + 1'b1;
            if (do_rd) rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule // hscp_fifo
`default_nettype wire

/* File: hscp_port.sv */
// Host serial command port: serial slave, registers, two stream FIFOs and interrupt pin.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Each transaction opens with one address byte selecting the register.
// - After the address, one word is written in or read out, except on streaming and address-only registers.
// - Every data word is a whole number of bytes, width set by register.
// - Some addresses act on the address byte alone, with no data.
// - Command data is sampled at each rising serial clock edge.
// - Reply bits are stable through the high phase of the serial clock.
// - Streaming registers take many words per transaction through a FIFO.
// - FIFO contents build up across transactions toward a fill level.
// - Single-word transactions fill the stream FIFO just as well.
// - Status changes raise the interrupt only where their mask bit is set.
// - Interrupt mask register lives at address 1F.
// - Status register at address 40 tells the host what changed.
// - Oscillator enable low disables the port, freezes mask and status and drops osc_power_up_o; the stream FIFOs keep running.
// - Interrupt output is active low and open drain.
// - General reset low idles framing, clears mask and status and flushes both FIFOs.
module hscp_port #(
   parameter int FIFO_DEPTH = hscp_pkg::FIFO_DEPTH
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        general_reset_low_i,
   input  wire logic        oscillator_enable_pin_i,
   input  wire logic        serial_clk_i,
   input  wire logic        command_serial_in_i,
   input  wire logic        host_select_low_i,
   output logic             reply_data_o,
   output logic             reply_data_oe_n_o,
   output logic             host_interrupt_low_o,
   output logic             host_interrupt_low_oe_n_o,
   input  wire logic [15:0] status_event_i,
   output logic             osc_power_up_o,
   output logic [15:0]      irq_mask_o,
   output logic             core_reset_pulse_o,
   output logic [7:0]       stream_out_data_o,
   output logic             stream_out_valid_o,
   input  wire logic        stream_out_ready_i,
   input  wire logic [7:0]  stream_in_data_i,
   input  wire logic        stream_in_valid_i,
   output logic             stream_in_ready_o
);
   if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_depth
      $error("hscp_port needs a power-of-two FIFO depth of at least 2");
   end
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. The first stage of each pair feeds only its second stage.
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic       sclk_d_r;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= 5'h1d;
         sync2_r <= 5'h1d;
      end else if (ce_i) begin
         sync1_r <= {general_reset_low_i, oscillator_enable_pin_i, serial_clk_i,
                     command_serial_in_i, host_select_low_i};
         sync2_r <= sync1_r;
      end
   end
   logic greset_n;
   logic osc_en;
   logic sclk_s;
   logic command_serial_in_s;
   logic sel_n_s;
   assign {greset_n, osc_en, sclk_s, command_serial_in_s, sel_n_s} = sync2_r;
   // Port is alive only with reset released and oscillator enabled.
   logic port_on;
   assign port_on = greset_n && osc_en;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      // Reset to the idle high level of the serial clock so no false edge follows reset.
      if (!rst_n_i) sclk_d_r <= 1'b1;
      else if (ce_i) sclk_d_r <= sclk_s;
   end
   logic rise;
   logic fall;
   logic active;
   assign rise   = sclk_s && !sclk_d_r && active;
   assign fall   = !sclk_s && sclk_d_r && active;
   assign active = port_on && !sel_n_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial framing.
   typedef enum logic [1:0] {
      HS_ADDR = 2'b00,
      HS_WR   = 2'b01,
      HS_RD   = 2'b10,
      HS_DONE = 2'b11
   } hscp_state_t;
   hscp_state_t st_r;
   logic [7:0]  addr_r;
   logic [15:0] shin_r;
   logic [15:0] shout_r;
   logic [4:0]  bitc_r;
   logic        wr_done;
   logic        rd_load;
   logic [4:0]  wlen;
   logic        streaming;
   logic [7:0]  sfifo_rd_data;
   logic        sfifo_rd_valid;
   logic [15:0] status_r;
   logic [15:0] mask_r;
   logic [LW-1:0] in_level;
   logic        in_wr_ready;
   logic        out_rd_valid;
   logic [7:0]  out_rd_data;

   // Word width per register, always a whole number of bytes.
   always_comb begin
      streaming = 1'b0;
      wlen      = 5'(hscp_pkg::REG_W);
      if (addr_r == hscp_pkg::ADDR_STREAM_IN || addr_r == hscp_pkg::ADDR_STREAM_OUT) begin
         streaming = 1'b1;
         wlen      = 5'(hscp_pkg::BYTE_W);
      end
   end
   logic [7:0] addr_full;
   assign addr_full = {shin_r[6:0], command_serial_in_s};
   logic addr_only;
   assign addr_only = (addr_full == hscp_pkg::ADDR_FIFO_FLUSH) ||
                      (addr_full == hscp_pkg::ADDR_GEN_RESET);
   logic addr_read;
   // Bit 6 marks a read, except for the stream input, which the host writes.
   assign addr_read = addr_full[6] && (addr_full != hscp_pkg::ADDR_STREAM_IN);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r   <= HS_ADDR;
         addr_r <= 8'h00;
         shin_r <= 16'h0000;
         bitc_r <= 5'h00;
      end else if (ce_i) begin
         if (!active) begin
            st_r   <= HS_ADDR;
            bitc_r <= 5'h00;
         end else if (rise) begin
            shin_r <= {shin_r[14:0], command_serial_in_s};
            bitc_r <= bitc_r + 5'h01;
            unique case (st_r)
               HS_ADDR: begin
                  if (bitc_r == 5'h07) begin
                     addr_r <= addr_full;
                     bitc_r <= 5'h00;
                     st_r   <= addr_only ? HS_DONE : (addr_read ? HS_RD : HS_WR);
                  end
               end
               HS_WR, HS_RD: begin
                  if (bitc_r == wlen - 5'h01) begin
                     bitc_r <= 5'h00;
                     st_r   <= streaming ? st_r : HS_DONE;
                  end
               end
               HS_DONE: bitc_r <= 5'h00;
            endcase
         end
      end
   end
   assign wr_done = rise && st_r == HS_WR && bitc_r == wlen - 5'h01;
   logic [15:0] wr_word;
   assign wr_word = {shin_r[14:0], command_serial_in_s};
   logic addr_end;
   assign addr_end = rise && st_r == HS_ADDR && bitc_r == 5'h07;
   assign rd_load  = (addr_end && addr_read && !addr_only) ||
                     (rise && st_r == HS_RD && bitc_r == wlen - 5'h01 && streaming);

   ////////////////////////////////////////////////////////////////////////////////
   // Reply shifter. Shifts on the falling edge so each bit holds through clock high.
   logic [15:0] rd_word;
   logic [7:0]  rd_addr;
   assign rd_addr = addr_end ? addr_full : addr_r;
   always_comb begin
      rd_word = 16'h0000;
      if (rd_addr == hscp_pkg::ADDR_STATUS) rd_word = status_r;
      else if (rd_addr == hscp_pkg::ADDR_STREAM_OUT) rd_word = {out_rd_data, 8'h00};
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shout_r           <= 16'h0000;
         reply_data_o      <= 1'b0;
         reply_data_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         reply_data_oe_n_o <= !(active && (st_r == HS_RD || rd_load));
         if (rd_load) begin
            shout_r <= rd_word;
         end else if (fall && st_r == HS_RD) begin
            reply_data_o <= shout_r[15];
            shout_r      <= {shout_r[14:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stream FIFOs, kept across transactions until flushed.
   logic flush;
   assign flush = (addr_end && addr_full == hscp_pkg::ADDR_FIFO_FLUSH) || !greset_n;
   logic in_push;
   assign in_push = wr_done && addr_r == hscp_pkg::ADDR_STREAM_IN;
   logic out_pop;
   assign out_pop = rd_load && rd_addr == hscp_pkg::ADDR_STREAM_OUT && out_rd_valid;
   logic sfifo_rd_ready;
   assign sfifo_rd_ready = stream_out_ready_i || !stream_out_valid_o;
   hscp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_in_fifo (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .flush_i    (flush),
      .wr_valid_i (in_push),
      .wr_ready_o (in_wr_ready),
      .wr_data_i  (wr_word[7:0]),
      .rd_ready_i (sfifo_rd_ready),
      .rd_valid_o (sfifo_rd_valid),
      .rd_data_o  (sfifo_rd_data),
      .level_o    (in_level)
   );
   hscp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_out_fifo (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .flush_i    (flush),
      .wr_valid_i (stream_in_valid_i),
      .wr_ready_o (stream_in_ready_o),
      .wr_data_i  (stream_in_data_i),
      .rd_ready_i (out_pop),
      .rd_valid_o (out_rd_valid),
      .rd_data_o  (out_rd_data),
      .level_o    ()
   );
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stream_out_valid_o <= 1'b0;
         stream_out_data_o  <= 8'h00;
      end else if (ce_i && sfifo_rd_ready) begin
         stream_out_valid_o <= sfifo_rd_valid;
         stream_out_data_o  <= sfifo_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mask, status and interrupt pin.
   logic [15:0] ev;
   // Bits 3 to 0: output empty, output underrun, input overrun, input full.
   assign ev = status_event_i |
               {12'h000, !out_rd_valid,
                rd_load && !out_rd_valid && rd_addr == hscp_pkg::ADDR_STREAM_OUT,
                in_push && !in_wr_ready, in_level == LW'(FIFO_DEPTH)};
   logic status_rd_end;
   assign status_rd_end = rise && st_r == HS_RD && bitc_r == wlen - 5'h01 &&
                          addr_r == hscp_pkg::ADDR_STATUS;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_r   <= hscp_pkg::MASK_RESET;
         status_r <= hscp_pkg::STATUS_RESET;
      end else if (ce_i) begin
         // Powersave only freezes the registers; the general reset clears both, and a status read clears the status.
         if (!greset_n) begin
            mask_r   <= hscp_pkg::MASK_RESET;
            status_r <= hscp_pkg::STATUS_RESET;
         end else if (osc_en) begin
            if (wr_done && addr_r == hscp_pkg::ADDR_IRQ_MASK) mask_r <= wr_word;
            // Reading clears the status, but a new event in that cycle wins.
            status_r <= (status_rd_end ? 16'h0000 : status_r) | ev;
         end
      end
   end
   assign irq_mask_o = mask_r;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_interrupt_low_oe_n_o <= 1'b1;
         osc_power_up_o            <= 1'b0;
         core_reset_pulse_o        <= 1'b0;
      end else if (ce_i) begin
         host_interrupt_low_oe_n_o <= !(|(status_r & mask_r));
         osc_power_up_o            <= osc_en;
         core_reset_pulse_o        <= addr_end && addr_full == hscp_pkg::ADDR_GEN_RESET;
      end
   end
   assign host_interrupt_low_o = 1'b0;

   a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && !(|(status_r & mask_r)) |=> host_interrupt_low_oe_n_o)
      else $error("interrupt driven with no unmasked status");
   a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && (|(status_r & mask_r)) |=> !host_interrupt_low_oe_n_o)
      else $error("interrupt not pulled low");
   a_reply_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && sel_n_s |=> reply_data_oe_n_o)
      else $error("reply driven while deselected");
   a_reply_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      sclk_s && sclk_d_r |-> $stable(reply_data_o))
      else $error("reply changed during clock high");
   a_powersave_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && !osc_en |=> st_r == HS_ADDR)
      else $error("port active in powersave");
   a_addr_byte: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && addr_end && !addr_only |=> st_r != HS_ADDR)
      else $error("address byte did not end");
   a_addr_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && addr_end && addr_only |=> st_r == HS_DONE)
      else $error("address-only command expected data");
   a_mask_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && port_on && wr_done && addr_r == hscp_pkg::ADDR_IRQ_MASK |=> mask_r == $past(wr_word))
      else $error("mask register not written");
   a_stream_stay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && active && wr_done && streaming |=> st_r == HS_WR)
      else $error("stream ended after one word");
endmodule // hscp_port
`default_nettype wire

/* File: hscp_host_model.sv */
// Host-side serial bus model that frames transfers and samples replies.
`timescale 1ns/1ns
`default_nettype none
module hscp_host_model (
   input  wire logic clk_sys_i,
   input  wire logic reply_i,
   output logic      serial_clk_o,
   output logic      cmd_o,
   output logic      sel_n_o
);
   int unsigned stable_err = 0;
   initial begin
      serial_clk_o = 1'b1;
      cmd_o        = 1'b0;
      sel_n_o      = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // The serial clock idles high and only toggles inside a frame.
   task automatic xfer(input logic [7:0] addr, input int nbits, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      logic [39:0] sh;
      logic        r1;
      sh      = {addr, 32'h0000_0000} | ({8'h00, wdata} << (32 - nbits));
      rdata   = '0;
      sel_n_o <= 1'b0;
      wait_clk(4);
      for (int i = 0; i < 8 + nbits; i++) begin
         serial_clk_o <= 1'b0;
         cmd_o        <= sh[39];
         sh           = sh << 1;
         wait_clk(4);
         serial_clk_o <= 1'b1;
         wait_clk(2);
         r1 = reply_i;
         wait_clk(2);
         // Sampling twice in the high phase catches a reply bit that moves too early.
         // The address bits carry no reply, and the driver may switch on during the last one.
         if (i >= 8 && reply_i !== r1) stable_err++;
         if (i >= 8) rdata = {rdata[30:0], r1};
      end
      sel_n_o <= 1'b1;
      cmd_o   <= ~cmd_o;
      wait_clk(8);
   endtask
endmodule // hscp_host_model
`default_nettype wire

/* File: host_serial_command_port_bench.sv */
// Self-checking bench for the host serial command port.
`timescale 1ns/1ns
`default_nettype none
module host_serial_command_port_bench;
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  nbits;
      logic [15:0] wdata;
      logic [15:0] exp;
   } hscp_row_t;
   logic        clk = 1'b0, rst_n = 1'b0, gen_rst_n = 1'b1, osc_en = 1'b1;
   logic        sclk, cmd, sel_n, reply_o, reply_oe_n, irq_o, irq_oe_n;
   logic        osc_up, core_pulse, so_valid, so_ready = 1'b0;
   logic        si_valid = 1'b0, si_ready;
   logic [15:0] status_ev = 16'h0000, mask;
   logic [7:0]  so_data, si_data = 8'h00;
   logic [31:0] rd;
   // A released reply line shows the inverse so that a late driver turn-on is caught.
   wire         reply_line = reply_oe_n ? ~reply_o : reply_o;
   wire         irq_line = irq_oe_n ? 1'b1 : irq_o;
   logic [7:0]  got[$];
   logic [7:0]  exp_b[5] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5};
   hscp_row_t   rows[5];
   int          error_cnt = 0, tests_run = 0, pulse_cnt = 0;

   hscp_port dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
      .general_reset_low_i(gen_rst_n), .oscillator_enable_pin_i(osc_en),
      .serial_clk_i(sclk), .command_serial_in_i(cmd), .host_select_low_i(sel_n),
      .reply_data_o(reply_o), .reply_data_oe_n_o(reply_oe_n),
      .host_interrupt_low_o(irq_o), .host_interrupt_low_oe_n_o(irq_oe_n),
      .status_event_i(status_ev), .osc_power_up_o(osc_up), .irq_mask_o(mask),
      .core_reset_pulse_o(core_pulse), .stream_out_data_o(so_data),
      .stream_out_valid_o(so_valid), .stream_out_ready_i(so_ready),
      .stream_in_data_i(si_data), .stream_in_valid_i(si_valid),
      .stream_in_ready_o(si_ready));
   hscp_host_model host_u (.clk_sys_i(clk), .reply_i(reply_line), .serial_clk_o(sclk),
      .cmd_o(cmd), .sel_n_o(sel_n));

   initial begin
      forever #4 clk = ~clk;
   end
   // Ready toggles every cycle so the stream sink stalls half the time.
   always @(posedge clk) so_ready <= ~so_ready;
   always @(negedge clk) begin
      if (so_valid === 1'b1 && so_ready === 1'b1) got.push_back(so_data);
      if (core_pulse === 1'b1) pulse_cnt++;
   end

   task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp1(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic pulse_event(input logic [15:0] v);
      @(posedge clk);
      status_ev <= v;
      @(posedge clk);
      status_ev <= 16'h0000;
   endtask
   task automatic wait_irq(input logic v);
      for (int n = 0; n < 40 && irq_line !== v; n++) @(negedge clk);
   endtask
   task automatic push_in(input logic [7:0] b);
      @(posedge clk);
      si_data  <= b;
      si_valid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         if (si_ready === 1'b1) break;
      end
      @(posedge clk);
      si_valid <= 1'b0;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   initial begin
      rows = '{'{hscp_pkg::ADDR_IRQ_MASK, 8'h10, 16'h8001, 16'h8001},
               '{hscp_pkg::ADDR_IRQ_MASK, 8'h10, 16'h1234, 16'h1234},
               '{hscp_pkg::ADDR_FIFO_FLUSH, 8'h00, 16'h0000, 16'h1234},
               '{hscp_pkg::ADDR_IRQ_MASK, 8'h10, 16'ha5c3, 16'ha5c3},
               '{hscp_pkg::ADDR_IRQ_MASK, 8'h10, 16'h0020, 16'h0020}};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmp16("mask_reset", hscp_pkg::MASK_RESET, mask);
      cmp1("reply_oe_n_idle", 1'b1, reply_oe_n);
      cmp1("irq_idle", 1'b1, irq_line);
      foreach (rows[k]) begin
         host_u.xfer(rows[k].addr, int'(rows[k].nbits), {16'h0000, rows[k].wdata}, rd);
         cmp16("mask_row", rows[k].exp, mask);
         cmp1("reply_released", 1'b1, reply_oe_n);
      end
      pulse_event(16'h0020);
      wait_irq(1'b0);
      cmp1("irq_masked_event", 1'b0, irq_line);
      cmp1("irq_pin_value", 1'b0, irq_o);
      host_u.xfer(hscp_pkg::ADDR_STATUS, 16, 32'h0000_0000, rd);
      cmp16("status_bit5", 16'h0020, rd[15:0] & 16'hfff0);
      wait_irq(1'b1);
      cmp1("irq_released", 1'b1, irq_line);
      pulse_event(16'h0040);
      repeat (20) @(posedge clk);
      cmp1("irq_unmasked", 1'b1, irq_line);
      host_u.xfer(hscp_pkg::ADDR_STATUS, 16, 32'h0000_0000, rd);
      cmp16("status_bit6", 16'h0040, rd[15:0] & 16'hfff0);
      host_u.xfer(hscp_pkg::ADDR_STATUS, 16, 32'h0000_0000, rd);
      cmp16("status_cleared", 16'h0000, rd[15:0] & 16'hfff0);
      host_u.xfer(hscp_pkg::ADDR_STREAM_IN, 24, 32'h00a1_b2c3, rd);
      host_u.xfer(hscp_pkg::ADDR_STREAM_IN, 8, 32'h0000_00d4, rd);
      host_u.xfer(hscp_pkg::ADDR_STREAM_IN, 8, 32'h0000_00e5, rd);
      repeat (20) @(posedge clk);
      cmp16("stream_count", 16'h0005, 16'(got.size()));
      foreach (exp_b[k]) cmp16("stream_byte", {8'h00, exp_b[k]}, {8'h00, got[k]});
      push_in(8'h5a);
      push_in(8'h3c);
      cmp1("stream_in_ready", 1'b1, si_ready);
      host_u.xfer(hscp_pkg::ADDR_STREAM_OUT, 16, 32'h0000_0000, rd);
      cmp16("stream_read", 16'h5a3c, rd[15:0]);
      host_u.xfer(hscp_pkg::ADDR_GEN_RESET, 0, 32'h0000_0000, rd);
      cmp16("core_pulse_cycles", 16'h0001, 16'(pulse_cnt));
      @(posedge clk);
      osc_en <= 1'b0;
      repeat (10) @(posedge clk);
      cmp1("osc_powered_down", 1'b0, osc_up);
      host_u.xfer(hscp_pkg::ADDR_IRQ_MASK, 16, 32'h0000_ffff, rd);
      cmp16("mask_in_powersave", 16'h0020, mask);
      osc_en <= 1'b1;
      repeat (10) @(posedge clk);
      cmp1("osc_powered_up", 1'b1, osc_up);
      gen_rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      cmp16("mask_general_reset", hscp_pkg::MASK_RESET, mask);
      gen_rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      cmp16("reply_stable_high", 16'h0000, 16'(host_u.stable_err));
      end_of_test();
   end
endmodule // host_serial_command_port_bench
`default_nettype wire
